// file: logic/ebm_master.sv
// expanded bus master with private bus and cycle type outputs
// Overview of operation
// - rw high read, stable whole cycle
// - data phase waits for transfer_ack low
// - address_strobe high, low when stable, high
// - peripheral option: per-byte data strobes
// - peripheral option: open-drain bus_request when needed
// - peripheral option: open-drain bus_grant_ack when taking mastership
// - role strap latched in reset, then input
// - general option: data_strobe low in data phase
// - general option: byte selects low whole cycle, both = word
// - arb pins swap meaning with role
// - private bus shows unmodified internal address
// - write data on private bus every write
// - read private bus except on-chip or expanded
// - private-only transfers three periods, handshake used
// - cycle type codes valid with private strobe
// - branch only first fetch after jump/call/interrupt
// - interrupt stack writes and vector reads marked
// - clock output at half input rate
// - expanded cycles four standard, three fast
// - wait for bus, keep until internal reference
// - interrupt acknowledge: strobe, no byte selects
`timescale 1ns/1ps
`default_nettype none
module ebm_master
  import ebm_pkg::*;
(
  input wire logic sys_clk_i, // system clock
  input wire logic reset_n_i, // synchronous reset, active low
  input wire logic requestor_select_i, // role strap, general input later
  input wire logic peripheral_ctrl_option_i, // 1 peripheral, 0 general option
  input wire logic fast_cycle_select_i, // 1 selects three-period cycles
  input wire logic [SEG_W-1:0] seg_bits_i, // window segment bits
  input wire logic branch_taken_i, // jump, call or interrupt pulse
  input wire logic req_valid_i, // processor reference pending
  input wire ebm_req_type req_i, // reference, held until done
  output logic req_done_o, // reference finished
  output logic [DATA_W-1:0] rdata_o, // read data
  input wire logic [DATA_W-1:0] onchip_rdata_i, // on-chip read data
  input wire logic [DATA_W-1:0] ad_i, // expanded bus pins in
  output logic [DATA_W-1:0] ad_o, // expanded bus pins out
  output logic ad_oe_o, // expanded bus drive enable
  output ebm_ctl_type ctl_o, // expanded bus strobes
  input wire logic transfer_ack_n_i, // completion, active low
  output logic bus_request_o, // open drain level, always low
  output logic bus_request_oe_o, // open drain enable
  input wire logic bus_grant_n_i, // grant in, active low
  output logic bus_grant_ack_o, // open drain level, always low
  output logic bus_grant_ack_oe_o, // open drain enable
  input wire logic arb_input_n_i, // request or grant in
  output logic arb_output_n_o, // grant or request out
  input wire logic [DATA_W-1:0] pb_ad_i, // private bus pins in
  output logic [DATA_W-1:0] pb_ad_o, // private bus pins out
  output logic pb_ad_oe_o, // private bus drive enable
  output ebm_ctl_type pb_ctl_o, // private bus strobes
  input wire logic pb_ack_n_i, // private bus completion
  output logic [1:0] cycle_type_o, // cycle type code
  output logic system_clock_out_o, // divided clock out
  output logic gp_input_o // strap pin as general input
);

  typedef enum logic [2:0] {S_IDLE, S_ARB, S_ADDR, S_STRB, S_DATA, S_END} ebm_state_type;

  ebm_state_type state_q, state_d;
  ebm_req_type req_q;
  logic [DATA_W-1:0] ext_addr_q, rdata_q;
  logic role_q, fast_q, own_q, want_q, grant_q, branch_pend_q, clk_div_q, gp_q;
  logic [1:0] ct_q;
  logic req_mode, bus_own, granted_in, grant_set, release_now;
  logic is_ext, is_priv, in_cyc, data_ack, inta;

  // peripheral option can only request; otherwise the strap decides
  assign req_mode = role_q | peripheral_ctrl_option_i;
  assign granted_in = peripheral_ctrl_option_i ? !bus_grant_n_i : !arb_input_n_i;
  assign bus_own = req_mode ? own_q : !grant_q;
  // grant only while no cycle runs and none is starting
  assign grant_set = !req_mode && !grant_q && !arb_input_n_i && state_q == S_IDLE
    && !req_valid_i;
  // an internal reference hands the bus back
  assign release_now = req_mode && own_q && state_q == S_IDLE && req_valid_i
    && req_i.tgt != TGT_EXP;

  assign is_ext = req_q.tgt == TGT_EXP;
  assign is_priv = req_q.tgt == TGT_PRIV;
  assign inta = req_q.kind == K_INTA_EXT;
  assign in_cyc = state_q inside {S_ADDR, S_STRB, S_DATA, S_END};
  // on-chip targets finish without an external answer
  assign data_ack = is_ext ? !transfer_ack_n_i : (is_priv ? !pb_ack_n_i : 1'b1);

  // role strap caught while reset is held, later a plain input
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      role_q <= requestor_select_i;
      gp_q <= ROLE_RST;
    end else begin
      role_q <= role_q;
      gp_q <= requestor_select_i;
    end
  end

  // bus state machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (req_valid_i) begin
          if (req_i.tgt != TGT_EXP) begin
            state_d = S_ADDR;
          end else if (bus_own && !grant_set) begin
            state_d = S_ADDR;
          end else begin
            state_d = S_ARB;
          end
        end
      end
      S_ARB: begin
        if (bus_own) begin
          state_d = S_ADDR;
        end
      end
      S_ADDR: begin
        state_d = (is_ext && !fast_q) ? S_STRB : S_DATA;
      end
      S_STRB: begin
        state_d = S_DATA;
      end
      S_DATA: begin
        if (data_ack) begin
          state_d = S_END;
        end
      end
      S_END: begin
        state_d = S_IDLE;
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      state_q <= S_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // reference capture; window references take the segment bits
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      req_q <= '0;
      ext_addr_q <= WORD_RST;
      fast_q <= 1'b0;
    end else if (state_q == S_IDLE && req_valid_i) begin
      req_q <= req_i;
      ext_addr_q <= req_i.win ? {seg_bits_i, req_i.addr[WIN_W-1:0]} : req_i.addr;
      fast_q <= fast_cycle_select_i;
    end
  end

  // requestor side: ask, take over, keep until internal reference
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      own_q <= 1'b0;
      want_q <= 1'b0;
    end else if (release_now || !req_mode) begin
      own_q <= 1'b0;
      want_q <= 1'b0;
    end else if (state_q == S_ARB && !own_q) begin
      want_q <= 1'b1;
      own_q <= granted_in;
    end
  end

  // grantor side: hold grant until the request goes away
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      grant_q <= 1'b0;
    end else if (grant_set) begin
      grant_q <= 1'b1;
    end else if (arb_input_n_i || req_mode) begin
      grant_q <= 1'b0;
    end
  end

  // arbitration pins; open drain only ever pulls low
  assign bus_request_o = 1'b0;
  assign bus_request_oe_o = peripheral_ctrl_option_i && want_q && !own_q;
  assign bus_grant_ack_o = 1'b0;
  assign bus_grant_ack_oe_o = peripheral_ctrl_option_i && own_q;
  assign arb_output_n_o = peripheral_ctrl_option_i ? 1'b1
    : (req_mode ? !want_q : !grant_q);

  // read data source depends on where the reference went
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      rdata_q <= WORD_RST;
    end else if (state_q == S_DATA && data_ack && !req_q.write) begin
      case (req_q.tgt)
        TGT_ONCHIP: rdata_q <= onchip_rdata_i;
        TGT_EXP: rdata_q <= ad_i;
        default: rdata_q <= pb_ad_i;
      endcase
    end
  end
  assign rdata_o = rdata_q;
  assign req_done_o = state_q == S_END;

  // expanded bus strobes; never active while the bus is granted away
  always_comb begin
    ctl_o.rw = !(is_ext && in_cyc && req_q.write);
    ctl_o.as_n = !(is_ext && (state_q == S_STRB || state_q == S_DATA));
    ctl_o.ds_n = !(is_ext && !peripheral_ctrl_option_i && state_q == S_DATA);
    ctl_o.uds_n = !(is_ext && peripheral_ctrl_option_i && state_q == S_DATA
      && req_q.hi && !inta);
    ctl_o.lds_n = !(is_ext && peripheral_ctrl_option_i && state_q == S_DATA
      && req_q.lo && !inta);
    ctl_o.hb_n = !(is_ext && !peripheral_ctrl_option_i && in_cyc && req_q.hi && !inta);
    ctl_o.lb_n = !(is_ext && !peripheral_ctrl_option_i && in_cyc && req_q.lo && !inta);
  end

  // multiplexed pins: address first, then write data
  assign ad_o = (state_q == S_ADDR || state_q == S_STRB) ? ext_addr_q : req_q.wdata;
  assign ad_oe_o = is_ext && in_cyc && (state_q == S_ADDR || state_q == S_STRB
    || req_q.write);

  // private bus mirrors every reference with the raw address
  always_comb begin
    pb_ctl_o.rw = !(in_cyc && req_q.write);
    pb_ctl_o.as_n = !(state_q == S_STRB || state_q == S_DATA);
    pb_ctl_o.ds_n = !(!is_ext && state_q == S_DATA);
    pb_ctl_o.uds_n = 1'b1;
    pb_ctl_o.lds_n = 1'b1;
    pb_ctl_o.hb_n = !(in_cyc && req_q.hi && !inta);
    pb_ctl_o.lb_n = !(in_cyc && req_q.lo && !inta);
  end
  assign pb_ad_o = (state_q == S_ADDR || state_q == S_STRB) ? req_q.addr : req_q.wdata;
  // reads leave private pins floating after the address so a private target may answer there
  assign pb_ad_oe_o = in_cyc && (state_q == S_ADDR || state_q == S_STRB
    || req_q.write);

  // branch flag: set wins over the clear by a program fetch
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      branch_pend_q <= 1'b0;
    end else if (branch_taken_i) begin
      branch_pend_q <= 1'b1;
    end else if (state_q == S_IDLE && req_valid_i && req_i.kind == K_PROG) begin
      branch_pend_q <= 1'b0;
    end
  end

  // cycle type fixed at cycle start so it is steady under the strobe
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      ct_q <= CT_RST;
    end else if (state_q == S_IDLE && req_valid_i) begin
      case (req_i.kind)
        K_PROG: ct_q <= branch_pend_q ? CT_BRANCH : CT_PROG;
        K_DATA: ct_q <= CT_DATA;
        default: ct_q <= CT_INT;
      endcase
    end
  end
  assign cycle_type_o = ct_q;

  // clock output divider
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      clk_div_q <= 1'b0;
    end else begin
      clk_div_q <= !clk_div_q;
    end
  end
  assign system_clock_out_o = clk_div_q;
  assign gp_input_o = gp_q;

  // window and segment bits must rebuild a full address, else the mux drops bits
  if (SEG_W + WIN_W != DATA_W) begin : g_split_check
    $error("segment and window widths do not fill the address");
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  a_rw_held: assert property ((in_cyc && state_q != S_END) |=> $stable(ctl_o.rw))
    else $error("rw changed inside a cycle");
  a_ack_stretch: assert property ((state_q == S_DATA && is_ext && transfer_ack_n_i)
    |=> state_q == S_DATA)
    else $error("data phase left without transfer_ack");
  a_as_shape: assert property ((state_q == S_ADDR && is_ext) |-> ctl_o.as_n
    ##1 !ctl_o.as_n)
    else $error("address strobe shape wrong");
  a_lane_strobe: assert property (!ctl_o.uds_n |-> peripheral_ctrl_option_i
    && req_q.hi && state_q == S_DATA)
    else $error("upper strobe outside its data phase");
  a_req_pulls: assert property (bus_request_oe_o |-> !own_q && !bus_request_o)
    else $error("bus request while owning");
  a_ack_owner: assert property ($rose(own_q) && peripheral_ctrl_option_i
    |-> bus_grant_ack_oe_o && !bus_grant_ack_o && $past(granted_in))
    else $error("grant ack without grant");
  a_std_len: assert property ((state_q == S_ADDR && is_ext && !fast_q)
    |=> state_q == S_STRB ##1 state_q == S_DATA)
    else $error("standard cycle too short");
  a_fast_len: assert property ((state_q == S_ADDR && (fast_q || !is_ext))
    |=> state_q == S_DATA)
    else $error("three-period cycle too long");
  a_inta_sel: assert property ((in_cyc && is_ext && inta) |-> ctl_o.hb_n && ctl_o.lb_n)
    else $error("byte select in interrupt acknowledge");
  a_grant_quiet: assert property (grant_q |-> !ad_oe_o && ctl_o.as_n)
    else $error("driving bus while granted");
  a_pb_addr: assert property ((state_q == S_IDLE && req_valid_i && state_d == S_ADDR)
    |=> pb_ad_o == req_i.addr)
    else $error("private address altered");
  // arbitration, data strobe, cycle type and clock checks
  a_grant_idle: assert property (grant_q |-> state_q inside {S_IDLE, S_ARB})
    else $error("grant given during a cycle");
  a_wait_bus: assert property ((state_q == S_ARB && !bus_own) |=> state_q == S_ARB)
    else $error("cycle started without the bus");
  a_release_drop: assert property (release_now
    |=> !bus_request_oe_o && !bus_grant_ack_oe_o && arb_output_n_o)
    else $error("bus kept after an internal reference");
  a_ds_phase: assert property (!ctl_o.ds_n
    |-> !peripheral_ctrl_option_i && state_q == S_DATA)
    else $error("data strobe outside general data phase");
  a_ct_steady: assert property (!pb_ctl_o.as_n
    |=> pb_ctl_o.as_n || $stable(cycle_type_o))
    else $error("cycle type moved under the private strobe");
  a_clk_half: assert property (1'b1 |=> system_clock_out_o != $past(system_clock_out_o))
    else $error("clock output missed a toggle");

  // scenario coverage
  c_ext_read: cover property (state_q == S_ADDR && is_ext && !req_q.write
    ##[1:8] req_done_o);
  c_arb_gain: cover property (state_q == S_ARB ##[1:20] state_q == S_ADDR);
  c_branch: cover property (state_q == S_ADDR && ct_q == CT_BRANCH);
  c_pb_read: cover property (state_q == S_DATA && is_priv && !req_q.write);
  c_grant_out: cover property ($rose(grant_q));
endmodule // ebm_master
`default_nettype wire

// file: logic/ebm_pkg.sv
// constants and carrier types for the expanded bus master
package ebm_pkg;
  localparam int DATA_W = 16;
  localparam int SEG_W = 2;
  localparam int WIN_W = 14;
  // bus cycle lengths in clock periods
  localparam int STD_PERIODS = 4;
  localparam int FAST_PERIODS = 3;
  localparam int PRIV_PERIODS = 3;
  // system clock output divides the input clock by this
  localparam int CLK_DIV = 2;
  // cycle type codes (hi bit, lo bit)
  localparam logic [1:0] CT_INT = 2'h0;
  localparam logic [1:0] CT_DATA = 2'h1;
  localparam logic [1:0] CT_BRANCH = 2'h2;
  localparam logic [1:0] CT_PROG = 2'h3;
  // values after reset
  localparam logic ROLE_RST = 1'b0;
  localparam logic [1:0] CT_RST = 2'h3;
  localparam logic [15:0] WORD_RST = 16'h0000;

  typedef enum logic [1:0] {TGT_ONCHIP, TGT_EXP, TGT_PRIV} ebm_tgt_type;
  typedef enum logic [1:0] {K_PROG, K_DATA, K_INT, K_INTA_EXT} ebm_kind_type;

  // one processor reference
  typedef struct packed {
    logic write;
    logic hi;
    logic lo;
    logic win;
    ebm_tgt_type tgt;
    ebm_kind_type kind;
    logic [DATA_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ebm_req_type;

  // bus control strobes, all active low except rw (high = read)
  typedef struct packed {
    logic rw;
    logic as_n;
    logic ds_n;
    logic uds_n;
    logic lds_n;
    logic hb_n;
    logic lb_n;
  } ebm_ctl_type;
endpackage

// file: sim/ebm_far_model.sv
// far side: memory target, slow arbiter and private bus responder
`timescale 1ns/1ps
`default_nettype none
module ebm_far_model
  import ebm_pkg::*;
#(parameter logic [15:0] PB_WORD = 16'h0000)
(
  input wire logic sys_clk_i, // clock
  input wire logic [3:0] wait_i, // wait cycles per data phase
  input wire logic other_req_i, // another master wants the bus
  input wire logic requestor_i, // device strapped as requestor
  input wire logic [15:0] ad_i, // device bus out
  input wire logic ad_oe_i, // device drives bus
  input wire ebm_ctl_type ctl_i, // bus strobes
  input wire ebm_ctl_type pb_ctl_i, // private strobes
  input wire logic arb_out_n_i, // device arb output
  input wire logic breq_oe_i, // request pulled low
  output logic [15:0] rd_o, // bus into device
  output logic ack_n_o, // transfer ack
  output logic grant_n_o, // bus grant
  output logic arb_in_n_o, // device arb input
  output logic [15:0] pb_rd_o, // private data
  output logic pb_ack_n_o, // private ack
  output logic [15:0] addr_o, // last latched address
  output logic [15:0] wdata_o // last written word
);
  logic [15:0] mem_q [0:15];
  logic prev_q = 1'h0;
  int cnt_q = 0;
  int gcnt_q = 0;
  wire logic strb = !ctl_i.ds_n || !ctl_i.uds_n || !ctl_i.lds_n;
  wire logic hit = strb && cnt_q >= int'(wait_i);
  wire logic rq = breq_oe_i || (requestor_i && !arb_out_n_i);
  wire logic [15:0] word = mem_q[addr_o[4:1]];
  initial begin
    {ack_n_o, grant_n_o, arb_in_n_o, pb_ack_n_o} = 4'hF;
    {rd_o, pb_rd_o, addr_o, wdata_o} = '0;
  end
  // moves on falling edges so the device samples settled levels
  always @(negedge sys_clk_i) begin
    prev_q <= strb;
    cnt_q <= strb ? cnt_q + 1 : 0;
    if (ad_oe_i && !strb && !prev_q) addr_o <= ad_i;
    ack_n_o <= !hit;
    if (hit && !ctl_i.rw) begin
      mem_q[addr_o[4:1]] <= ad_i;
      wdata_o <= ad_i;
    end
    // an ungated lane shows the inverse, so a stale copy never passes
    rd_o[15:8] <= (strb && ctl_i.rw && !(ctl_i.ds_n && ctl_i.uds_n)) ? word[15:8] :
      ~rd_o[15:8];
    rd_o[7:0] <= (strb && ctl_i.rw && !(ctl_i.ds_n && ctl_i.lds_n)) ? word[7:0] :
      ~rd_o[7:0];
    // private activity is ignored while an expanded access runs
    pb_ack_n_o <= pb_ctl_i.ds_n || !ctl_i.as_n;
    pb_rd_o <= (!pb_ctl_i.ds_n && pb_ctl_i.rw) ? PB_WORD : ~pb_rd_o;
    // slow arbiter: grant only after two cycles of request
    gcnt_q <= rq ? gcnt_q + 1 : 0;
    grant_n_o <= !(breq_oe_i && gcnt_q >= 2);
    arb_in_n_o <= requestor_i ? !(rq && gcnt_q >= 2) : !other_req_i;
  end
endmodule // ebm_far_model
`default_nettype wire

// file: sim/testbench.sv
// self-checking bench for the expanded bus master
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ebm_pkg::*;
  localparam logic [15:0] PB_WORD = 16'hC3A5;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic strap = 1'h0;
  logic periph = 1'h0;
  logic fast = 1'h0;
  logic branch = 1'h0;
  logic valid = 1'h0;
  logic other_req = 1'h0;
  logic rmode = 1'h0;
  logic [3:0] wait_n = 4'h0;
  ebm_req_type req = '0;
  wire logic done, ad_oe, ack_n, breq_oe, grant_n, bga_oe, arb_in_n, arb_out_n, pb_ack_n, sco, gpi;
  wire logic [15:0] rdata, ad_i, ad_o, pb_ad_i, pb_ad_o, addr_seen, wd_seen;
  wire logic [1:0] ct;
  wire logic pb_oe;
  wire ebm_ctl_type ctl, pb_ctl;
  logic [15:0] n_cyc, n_astb, n_dstb, n_hsel, n_lsel, n_ustb, n_lstb, rw_bad, ct0, pb0, pbw, rd;
  logic oe_seen, breq_seen, bga, pbo;
  int num_errors = 0;
  int n_compared = 0;

  always #10 clk = ~clk;

  ebm_master dut (
    .sys_clk_i(clk), .reset_n_i(rst_n), .requestor_select_i(strap),
    .peripheral_ctrl_option_i(periph), .fast_cycle_select_i(fast), .seg_bits_i(2'h2),
    .branch_taken_i(branch), .req_valid_i(valid), .req_i(req), .req_done_o(done),
    .rdata_o(rdata), .onchip_rdata_i(16'h3C3C), .ad_i(ad_i), .ad_o(ad_o), .ad_oe_o(ad_oe),
    .ctl_o(ctl), .transfer_ack_n_i(ack_n), .bus_request_o(), .bus_request_oe_o(breq_oe),
    .bus_grant_n_i(grant_n), .bus_grant_ack_o(), .bus_grant_ack_oe_o(bga_oe),
    .arb_input_n_i(arb_in_n), .arb_output_n_o(arb_out_n), .pb_ad_i(pb_ad_i),
    .pb_ad_o(pb_ad_o), .pb_ad_oe_o(pb_oe), .pb_ctl_o(pb_ctl), .pb_ack_n_i(pb_ack_n),
    .cycle_type_o(ct), .system_clock_out_o(sco), .gp_input_o(gpi)
  );

  ebm_far_model #(.PB_WORD(PB_WORD)) far (
    .sys_clk_i(clk), .wait_i(wait_n), .other_req_i(other_req), .requestor_i(rmode),
    .ad_i(ad_o), .ad_oe_i(ad_oe), .ctl_i(ctl), .pb_ctl_i(pb_ctl), .arb_out_n_i(arb_out_n),
    .breq_oe_i(breq_oe), .rd_o(ad_i), .ack_n_o(ack_n), .grant_n_o(grant_n),
    .arb_in_n_o(arb_in_n), .pb_rd_o(pb_ad_i), .pb_ack_n_o(pb_ack_n), .addr_o(addr_seen),
    .wdata_o(wd_seen)
  );

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  function automatic ebm_req_type mk(input logic w, hi, lo, win, input ebm_tgt_type t,
    input ebm_kind_type k, input logic [15:0] a, d);
    mk = '{w, hi, lo, win, t, k, a, d};
  endfunction

  task automatic rst(input logic s, p);
    @(negedge clk);
    {rst_n, strap, periph} = {1'h0, s, p};
    repeat (16) @(negedge clk);
    rst_n = 1'h1;
  endtask

  // one reference, counting strobe cycles until the done pulse
  task automatic do_ref(input ebm_req_type r);
    int k;
    {n_cyc, n_astb, n_dstb, n_hsel, n_lsel, n_ustb, n_lstb, rw_bad} = '0;
    {oe_seen, breq_seen} = 2'h0;
    check("reserved space", 16'(r.addr >= 16'hFC00), 16'h0000);
    @(negedge clk);
    req = r;
    valid = 1'h1;
    for (k = 0; k < 200; k++) begin
      @(negedge clk);
      n_cyc++;
      if (k == 0) {ct0, pb0} = {14'h0, ct, pb_ad_o};
      n_astb += 16'(ctl.as_n === 1'h0);
      n_dstb += 16'(ctl.ds_n === 1'h0);
      n_hsel += 16'(ctl.hb_n === 1'h0);
      n_lsel += 16'(ctl.lb_n === 1'h0);
      n_ustb += 16'(ctl.uds_n === 1'h0);
      n_lstb += 16'(ctl.lds_n === 1'h0);
      if (ad_oe === 1'h1 && ctl.rw !== !r.write) rw_bad++;
      {oe_seen, breq_seen} = {oe_seen | ad_oe, breq_seen | breq_oe};
      if (done === 1'h1) break;
    end
    check("ref done", 16'(done), 16'h0001);
    {pbw, rd, bga, pbo} = {pb_ad_o, rdata, bga_oe, pb_oe};
    valid = 1'h0;
  endtask

  task automatic t_reset;
    logic c;
    check("idle strobes", 16'(ctl), 16'h007F);
    check("reset type", 16'(ct), 16'(CT_RST));
    c = sco;
    @(negedge clk);
    check("clock out half", 16'(sco), 16'(!c));
    @(negedge clk);
    check("clock out back", 16'(sco), 16'(c));
    $display("test reset ended");
  endtask

  task automatic t_expanded;
    do_ref(mk(1'h1, 1'h1, 1'h1, 1'h1, TGT_EXP, K_DATA, 16'h4008, 16'hA55A));
    check("std cycles", n_cyc, 16'h0004);
    check("addr strobe", n_astb, 16'h0002);
    check("data strobe", n_dstb, 16'h0001);
    check("high select", n_hsel, 16'h0004);
    check("low select", n_lsel, 16'h0004);
    check("rw write", rw_bad, 16'h0000);
    check("window addr", addr_seen, 16'h8008);
    check("bus data", wd_seen, 16'hA55A);
    check("pb addr", pb0, 16'h4008);
    check("pb data", pbw, 16'hA55A);
    check("data type", ct0, 16'(CT_DATA));
    {wait_n, fast} = {4'h3, 1'h1};
    do_ref(mk(1'h0, 1'h1, 1'h1, 1'h1, TGT_EXP, K_DATA, 16'h4008, 16'h0000));
    check("stretched cycles", n_cyc, 16'h0006);
    check("stretched strobe", n_dstb, 16'h0004);
    check("rw read", rw_bad, 16'h0000);
    check("read word", rd, 16'hA55A);
    wait_n = 4'h0;
    do_ref(mk(1'h0, 1'h1, 1'h1, 1'h1, TGT_EXP, K_DATA, 16'h4008, 16'h0000));
    check("fast cycles", n_cyc, 16'h0003);
    check("fast strobe", n_astb, 16'h0001);
    $display("test expanded ended");
  endtask

  task automatic t_local;
    do_ref(mk(1'h0, 1'h1, 1'h1, 1'h0, TGT_PRIV, K_DATA, 16'h0100, 16'h0000));
    check("private cycles", n_cyc, 16'h0003);
    check("private read", rd, PB_WORD);
    check("bus untouched", 16'(oe_seen), 16'h0000);
    check("pb free", 16'(pbo), 16'h0000);
    fast = 1'h0;
    @(negedge clk);
    branch = 1'h1;
    @(negedge clk);
    branch = 1'h0;
    do_ref(mk(1'h0, 1'h1, 1'h1, 1'h0, TGT_ONCHIP, K_PROG, 16'h0200, 16'h0000));
    check("branch type", ct0, 16'(CT_BRANCH));
    check("onchip read", rd, 16'h3C3C);
    do_ref(mk(1'h0, 1'h1, 1'h1, 1'h0, TGT_PRIV, K_PROG, 16'h0202, 16'h0000));
    check("fetch type", ct0, 16'(CT_PROG));
    check("slow private cycles", n_cyc, 16'h0003);
    check("private fetch", rd, PB_WORD);
    do_ref(mk(1'h1, 1'h1, 1'h1, 1'h0, TGT_ONCHIP, K_INT, 16'h0300, 16'h1234));
    check("int type", ct0, 16'(CT_INT));
    check("onchip write shown", pbw, 16'h1234);
    check("pb drive", 16'(pbo), 16'h0001);
    do_ref(mk(1'h0, 1'h1, 1'h1, 1'h0, TGT_EXP, K_INTA_EXT, 16'h0000, 16'h0000));
    check("ack high select", n_hsel, 16'h0000);
    check("ack low select", n_lsel, 16'h0000);
    check("ack strobe", n_astb, 16'h0002);
    check("ack type", ct0, 16'(CT_INT));
    $display("test local ended");
  endtask

  task automatic t_arbitration;
    other_req = 1'h1;
    repeat (4) @(negedge clk);
    check("grant out", 16'(arb_out_n), 16'h0000);
    fork
      do_ref(mk(1'h1, 1'h1, 1'h1, 1'h0, TGT_EXP, K_DATA, 16'h0020, 16'h5AA5));
      begin
        repeat (6) @(negedge clk);
        check("bus released", 16'(ad_oe), 16'h0000);
        other_req = 1'h0;
      end
    join
    check("held off", 16'(n_cyc > 16'h0006), 16'h0001);
    rst(1'h1, 1'h0);
    {rmode, strap} = 2'h3;
    repeat (3) @(negedge clk);
    check("strap as input", 16'(gpi), 16'h0001);
    do_ref(mk(1'h1, 1'h0, 1'h1, 1'h0, TGT_EXP, K_DATA, 16'h0030, 16'h00C3));
    check("waited grant", 16'(n_cyc > 16'h0004), 16'h0001);
    check("low lane only", n_lsel - n_hsel, 16'h0004);
    check("bus kept", 16'(arb_out_n), 16'h0000);
    do_ref(mk(1'h0, 1'h1, 1'h1, 1'h0, TGT_ONCHIP, K_DATA, 16'h0200, 16'h0000));
    check("bus dropped", 16'(arb_out_n), 16'h0001);
    rmode = 1'h0;
    rst(1'h0, 1'h1);
    do_ref(mk(1'h1, 1'h1, 1'h0, 1'h0, TGT_EXP, K_DATA, 16'h0040, 16'hBE00));
    check("upper strobe", n_ustb, 16'h0001);
    check("lower strobe", n_lstb, 16'h0000);
    check("upper byte", 16'(wd_seen[15:8]), 16'h00BE);
    check("request pulled", 16'(breq_seen), 16'h0001);
    check("grant ack", 16'(bga), 16'h0001);
    $display("test arbitration ended");
  endtask

  initial begin
    rst(1'h0, 1'h0);
    t_reset;
    t_expanded;
    t_local;
    t_arbitration;
    final_report;
  end

  // the tests need well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk);
    num_errors++;
    final_report;
  end
endmodule // testbench
`default_nettype wire
